// ===== hw/pss_pkg.sv
/*
 * Package for the pipelined synchronous SRAM pin-control block: widths, lane layout,
 * burst order encoding and the packed carriers for the pin groups.
 * Assumes a single clock domain; the user of the package imports nothing and scopes every name.
 */
package pss_pkg;

    localparam int ADDR_W  = 18;
    localparam int DEPTH   = 262144;
    localparam int DATA_W  = 16;
    localparam int PAR_W   = 2;
    localparam int LANES   = 2;
    localparam int LANE_W  = 8;
    localparam int BURST_W = 2;
    localparam int WORD_W  = DATA_W + PAR_W;

    // Depth of the strap synchroniser; the strap counts once the last two stages agree.
    localparam int SYNC_STAGES = 3;

    // Strap level that selects the interleaved burst order; the other level selects linear.
    localparam logic MODE_INTERLEAVED = 1'b1;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h0_0000;
    localparam logic [WORD_W-1:0] WORD_RESET = 18'h0_0000;

    // Synchronous control pins as presented by the controller.
    typedef struct packed {
        logic                 clock_qualify_n;
        logic                 advance_or_load;
        logic                 write_n;
        logic                 chip_select_low_a;
        logic                 chip_select_high;
        logic                 chip_select_low_b;
        logic [LANES-1:0]     byte_lane_write_select_n;
        logic [ADDR_W-1:0]    addr;
    } pss_ctrl_type;

    // Data word: sixteen data bits plus one parity bit per lane.
    typedef struct packed {
        logic [PAR_W-1:0]     parity_lines;
        logic [DATA_W-1:0]    data;
    } pss_word_type;

endpackage : pss_pkg

// ===== hw/pss_sram.sv
/*
 * Pipelined synchronous burst SRAM, control and storage behind the pins.
 * Assumes every synchronous input is driven by logic on clock_i, so none is resynchronised;
 * only the asynchronous output enable is treated combinationally at the data drivers.
 * The burst-order strap is a board level, so it passes a synchroniser that runs during reset
 * and is caught once the last two stages agree; it is expected to be steady across reset release.
 * Reads and writes may alternate on every qualified edge; a read right behind a write sees its data.
 */
`timescale 1ns/1ps

// Summary of operation
// - An 18-bit word address picks one of 262,144 words and is captured on a qualified rising edge that selects the part.
// - The active-low lane selects are sampled at the edge and a lane is written only when low during a write.
// - Lane 0 covers data bits 7 to 0 and parity bit 0, lane 1 covers data bits 15 to 8 and parity bit 1.
// - Edges count only while the clock qualifier is low, otherwise no input but the burst-order strap is sampled.
// - Advance/load high at a qualified edge steps the internal burst counter.
// - Advance/load low at a qualified edge loads the presented address for a new access.
// - The part is selected only for chip selects low, high, low at the edge, any other mix deselects.
// - The asynchronous active-low output enable lets the data pins drive only while low.
// - In the data cycle of a write the drivers stay off whatever the output enable says.
// - In the first cycle after leaving deselect the drivers stay off whatever the output enable says.
// - While the qualifier is high all internal state but the strap synchroniser and strap capture holds, and the part is not deselected.
// - Read data on the pins belongs to the address captured at the previous qualified edge.
// - A static strap chooses interleaved order when high and linear order when low.
module pss_sram (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // Synchronous control and strap
    input  wire pss_pkg::pss_ctrl_type     ctrl_i,
    input  wire logic                      burst_mode_i,
    // Asynchronous output enable, active low
    input  wire logic                      output_enable_n_i,
    // Data and parity pins
    input  wire pss_pkg::pss_word_type     word_i,
    output pss_pkg::pss_word_type          word_o,
    output logic [pss_pkg::WORD_W-1:0]     word_oe_o
);

    typedef enum logic [1:0] {
        PSS_IDLE,
        PSS_READ,
        PSS_WRITE
    } pss_cycle_type;

    logic [pss_pkg::WORD_W-1:0]   mem_r [pss_pkg::DEPTH];

    pss_cycle_type                cycle_r,      cycle_nxt;
    logic [pss_pkg::ADDR_W-1:0]   addr_r,       addr_nxt;
    logic [pss_pkg::BURST_W-1:0]  start_r,      start_nxt;
    logic [pss_pkg::BURST_W-1:0]  step_r,       step_nxt;
    logic [pss_pkg::LANES-1:0]    lanes_r,      lanes_nxt;
    logic                         fresh_r,      fresh_nxt;
    logic                         mode_r,       mode_nxt;
    logic                         mode_seen_r,  mode_seen_nxt;
    logic [pss_pkg::WORD_W-1:0]   rdata_r,      rdata_nxt;
    logic                         drive_r,      drive_nxt;
    logic [pss_pkg::SYNC_STAGES-1:0] strap_r,   strap_nxt;

    logic                         qual;
    logic                         select;
    logic [pss_pkg::ADDR_W-1:0]   op_addr;
    logic [pss_pkg::BURST_W-1:0]  op_step;
    logic [pss_pkg::BURST_W-1:0]  op_start;
    // Write completing at this edge and the word it leaves in the array.
    logic                         wr_now;
    logic [pss_pkg::WORD_W-1:0]   wr_word;

    // Burst position from the starting offset and step count in the strapped order.
    function automatic logic [pss_pkg::BURST_W-1:0] burst_offset(
        input logic [pss_pkg::BURST_W-1:0] start,
        input logic [pss_pkg::BURST_W-1:0] step,
        input logic                        interleaved
    );
        if (interleaved) begin
            burst_offset = start ^ step;
        end else begin
            burst_offset = start + step;
        end
    endfunction : burst_offset

    // Word written at the end of a write data cycle: enabled lanes from the pins, the rest kept.
    function automatic logic [pss_pkg::WORD_W-1:0] lane_merge(
        input logic [pss_pkg::WORD_W-1:0] old_word,
        input pss_pkg::pss_word_type      new_word,
        input logic [pss_pkg::LANES-1:0]  lanes
    );
        pss_pkg::pss_word_type merged;
        merged = pss_pkg::pss_word_type'(old_word);
        for (int l = 0; l < pss_pkg::LANES; l++) begin
            if (lanes[l]) begin
                merged.data[l*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
                    new_word.data[l*pss_pkg::LANE_W +: pss_pkg::LANE_W];
                merged.parity_lines[l] = new_word.parity_lines[l];
            end
        end
        lane_merge = merged;
    endfunction : lane_merge

    assign qual   = ~ctrl_i.clock_qualify_n;
    assign select = ~ctrl_i.chip_select_low_a & ctrl_i.chip_select_high
                  & ~ctrl_i.chip_select_low_b;

    // A write completes at the first qualified edge after its command, with the word then on the pins.
    assign wr_now  = qual && (cycle_r == PSS_WRITE);
    assign wr_word = lane_merge(mem_r[addr_r], word_i, lanes_r);

    // Strap synchroniser. It has no reset so that it is already filled when reset is released,
    // and only its last two stages are read.
    always_comb begin
        strap_nxt = {strap_r[pss_pkg::SYNC_STAGES-2:0], burst_mode_i};
    end

    always_ff @(posedge clock_i) begin
        strap_r <= strap_nxt;
    end

    // Address of the access being started at this edge, loaded or advanced.
    always_comb begin
        op_start = start_r;
        op_step  = step_r + 2'h1;
        op_addr  = {addr_r[pss_pkg::ADDR_W-1:pss_pkg::BURST_W], burst_offset(start_r, op_step, mode_r)};
        if (!ctrl_i.advance_or_load) begin
            op_start = ctrl_i.addr[pss_pkg::BURST_W-1:0];
            op_step  = 2'h0;
            op_addr  = ctrl_i.addr;
        end
    end

    // Command stage: the edge takes the command, the following cycle is its data cycle.
    always_comb begin
        cycle_nxt     = cycle_r;
        addr_nxt      = addr_r;
        start_nxt     = start_r;
        step_nxt      = step_r;
        lanes_nxt     = lanes_r;
        fresh_nxt     = fresh_r;
        mode_nxt      = mode_r;
        mode_seen_nxt = mode_seen_r;
        // The strap is caught once after reset release, since it must not move in service; a strap
        // that is still settling leaves the interleaved order in force until the stages agree.
        if (!mode_seen_r
            && (strap_r[pss_pkg::SYNC_STAGES-1] == strap_r[pss_pkg::SYNC_STAGES-2])) begin
            mode_nxt      = (strap_r[pss_pkg::SYNC_STAGES-1] == pss_pkg::MODE_INTERLEAVED);
            mode_seen_nxt = 1'b1;
        end
        if (qual) begin
            fresh_nxt = (cycle_r == PSS_IDLE) && select;
            if (!select) begin
                cycle_nxt = PSS_IDLE;
            end else begin
                // Advancing straight out of deselect is the controller's fault; the old burst steps on from its last address.
                addr_nxt  = op_addr;
                start_nxt = op_start;
                step_nxt  = op_step;
                lanes_nxt = ~ctrl_i.byte_lane_write_select_n;
                cycle_nxt = ctrl_i.write_n ? PSS_READ : PSS_WRITE;
            end
        end
    end

    // Data stage: read word registered out; write data taken from the pins at the next qualified edge.
    always_comb begin
        rdata_nxt = rdata_r;
        drive_nxt = drive_r;
        if (qual) begin
            // The first cycle out of deselect is masked at the pins by fresh_r, not here.
            drive_nxt = select && ctrl_i.write_n;
            if (select && ctrl_i.write_n) begin
                rdata_nxt = mem_r[op_addr];
                // A write that lands at this same edge is not in the array yet, so a read of that
                // word right behind it takes the merged word instead of the stale one.
                if (wr_now && (op_addr == addr_r)) begin
                    rdata_nxt = wr_word;
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cycle_r     <= PSS_IDLE;
            addr_r      <= pss_pkg::ADDR_RESET;
            start_r     <= 2'h0;
            step_r      <= 2'h0;
            lanes_r     <= 2'h0;
            fresh_r     <= 1'b0;
            mode_r      <= pss_pkg::MODE_INTERLEAVED;
            mode_seen_r <= 1'b0;
            rdata_r     <= pss_pkg::WORD_RESET;
            drive_r     <= 1'b0;
        end else begin
            cycle_r     <= cycle_nxt;
            addr_r      <= addr_nxt;
            start_r     <= start_nxt;
            step_r      <= step_nxt;
            lanes_r     <= lanes_nxt;
            fresh_r     <= fresh_nxt;
            mode_r      <= mode_nxt;
            mode_seen_r <= mode_seen_nxt;
            rdata_r     <= rdata_nxt;
            drive_r     <= drive_nxt;
        end
    end

    // Storage has no reset, as in a real array; lanes that are not enabled keep their old bits.
    always_ff @(posedge clock_i) begin
        if (wr_now) begin
            mem_r[addr_r] <= wr_word;
        end
    end

    // Drivers are on only for a registered read that is not the first cycle out of deselect.
    assign word_o    = pss_pkg::pss_word_type'(rdata_r);
    assign word_oe_o = {pss_pkg::WORD_W{drive_r & ~fresh_r & ~output_enable_n_i}};

endmodule : pss_sram

// ===== tb/pss_ctrl_model.sv
/* Controller model: puts each bench command on the pins a clock later and drives write data.
   Assumes one command per clock from the bench. */
`timescale 1ns/1ps
module pss_ctrl_model (
    input  wire pss_pkg::pss_ctrl_type cmd_i,
    input  wire logic                  clock_i,
    input  wire pss_pkg::pss_word_type wdata_i,
    output pss_pkg::pss_ctrl_type      ctrl_o = '0,
    output pss_pkg::pss_word_type      word_o = '0
);
    pss_pkg::pss_word_type pend_r;
    // Released data lines toggle so a stale value can never pass as write data.
    always @(posedge clock_i) begin
        ctrl_o <= cmd_i;
        pend_r <= wdata_i;
        if (!ctrl_o.clock_qualify_n && !ctrl_o.write_n && ctrl_o[22:20] == 3'b010)
            word_o <= pend_r;
        else if (!ctrl_o.clock_qualify_n)
            word_o <= ~word_o;
    end
endmodule : pss_ctrl_model

// ===== tb/pss_sram_assertions.sv
/* Checker of the output drive rules of pss_sram.
   Bound to pss_sram and sees only its ports. */
`timescale 1ns/1ps
module pss_sram_assertions (
    input wire logic                       clock_i,
    input wire logic                       rst_i,
    input wire pss_pkg::pss_ctrl_type      ctrl_i,
    input wire logic                       output_enable_n_i,
    input wire pss_pkg::pss_word_type      word_o,
    input wire logic [pss_pkg::WORD_W-1:0] word_oe_o
);
    logic qual, sel, rd, was_sel_r;
    assign qual = !ctrl_i.clock_qualify_n;
    assign sel  = ctrl_i[22:20] == 3'b010;
    assign rd   = qual && sel && ctrl_i.write_n && was_sel_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            was_sel_r <= 1'b0;
        else if (qual)
            was_sel_r <= sel;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_oe_gates: assert property (output_enable_n_i |-> word_oe_o == '0)
        else $error("drive with enable high");
    chk_write_off: assert property (qual && sel && !ctrl_i.write_n |=> word_oe_o == '0)
        else $error("drive in write data cycle");
    chk_first_off: assert property (qual && sel && !was_sel_r |=> word_oe_o == '0)
        else $error("drive after deselect");
    chk_desel_off: assert property (qual && !sel |=> word_oe_o == '0)
        else $error("drive while deselected");
    chk_read_on: assert property (rd |=> output_enable_n_i || word_oe_o == '1)
        else $error("read not driven");
    chk_hold_word: assert property (!qual |=> $stable(word_o))
        else $error("word moved while held");
    chk_hold_drive: assert property (!qual && !output_enable_n_i ##1 !output_enable_n_i |-> $stable(word_oe_o))
        else $error("drive moved while held");
    chk_suspend_sel: assert property (rd ##1 !qual |=> output_enable_n_i || word_oe_o == '1)
        else $error("suspend deselected");
endmodule : pss_sram_assertions
bind pss_sram pss_sram_assertions u_pss_sram_assertions (.clock_i, .rst_i, .ctrl_i, .output_enable_n_i, .word_o,
                                                         .word_oe_o);

// ===== tb/pss_sram_bench.sv
/* Self-checking bench of pss_sram with a reference model.
   Assumes the package, design and controller model are compiled first. */
`timescale 1ns/1ps
module pss_sram_bench;
    logic                  clock_i = 1'b0;
    logic                  rst_i   = 1'b1;
    logic                  mode    = 1'b1;
    logic                  oe_n    = 1'b0;
    pss_pkg::pss_ctrl_type cmd     = '0;
    pss_pkg::pss_word_type wd      = '0;
    pss_pkg::pss_ctrl_type ctrl;
    pss_pkg::pss_word_type din, dout;
    logic [17:0]           oe, exp_q, wa, base;
    logic [17:0]           mem[int];
    logic [1:0]            wl, step;
    logic                  drv, pend, last_sel, g_sel, s;
    int                    mismatches = 0;
    int                    n_checks   = 0;
    int                    cycles     = 0;
    pss_ctrl_model u_pss_ctrl_model (.clock_i, .cmd_i(cmd), .wdata_i(wd), .ctrl_o(ctrl), .word_o(din));
    pss_sram u_pss_sram (.clock_i, .rst_i, .ctrl_i(ctrl), .burst_mode_i(mode), .output_enable_n_i(oe_n),
                         .word_i(din), .word_o(dout), .word_oe_o(oe));
    task automatic cmp(string what, logic [17:0] e, logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic step_ref();
        logic [17:0] a;
        s = ctrl[22:20] == 3'b010;
        if (pend) begin
            a = mem.exists(wa) ? mem[wa] : 'x;
            if (!wl[0])
                a = {a[17], din[16], a[15:8], din[7:0]};
            if (!wl[1])
                a = {din[17], a[16], din[15:8], a[7:0]};
            mem[wa] = a;
        end
        if (ctrl.advance_or_load) begin
            step = step + 2'h1;
        end else begin
            base = ctrl.addr;
            step = 2'h0;
        end
        a = {base[17:2], (mode == pss_pkg::MODE_INTERLEAVED) ? base[1:0] ^ step : base[1:0] + step};
        pend = s && !ctrl.write_n;
        wa = a;
        wl = ctrl.byte_lane_write_select_n;
        drv = s && ctrl.write_n && last_sel;
        if (s && ctrl.write_n)
            exp_q = mem.exists(a) ? mem[a] : 'x;
        last_sel = s;
    endtask : step_ref
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (!rst_i) begin
            cmp("drive", {18{drv & ~oe_n}}, oe);
            if (drv && !oe_n && !$isunknown(exp_q))
                cmp("word", exp_q, dout);
            if (!ctrl.clock_qualify_n)
                step_ref();
        end
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        pss_pkg::pss_ctrl_type c;
        void'($urandom(32'hd766_38a5));
        for (int ph = 0; ph < 2; ph++) begin
            rst_i <= 1'b1;
            cmd <= '0;
            mode <= ph[0];
            repeat (4) @(posedge clock_i);
            {drv, pend, last_sel, g_sel, step} = '0;
            rst_i <= 1'b0;
            repeat (1000) begin
                c.clock_qualify_n = ($urandom % 8) == 0;
                c.write_n = 1'($urandom);
                c[22:20] = ($urandom % 4) ? 3'b010 : 3'($urandom);
                c.byte_lane_write_select_n = 2'($urandom);
                c.addr = 18'($urandom) & 18'h3_c00f;
                c.advance_or_load = g_sel && c[22:20] == 3'b010 && ($urandom % 2);
                if (!c.clock_qualify_n)
                    g_sel = c[22:20] == 3'b010;
                cmd <= c;
                wd <= 18'($urandom);
                oe_n <= ($urandom % 4) == 0;
                @(posedge clock_i);
            end
        end
        conclude();
    end
endmodule : pss_sram_bench
